/* shared/pulse_timer_params.svh */
`ifndef PULSE_TIMER_PARAMS_SVH
`define PULSE_TIMER_PARAMS_SVH

// Register byte offsets on the plain register port.
`define CTRL_OFS 4'h0
`define PRESET_OFS 4'h4
`define STATUS_OFS 4'h8
`define COUNT_OFS 4'hC

// Control register fields.
`define CTRL_MODE_BIT 0
`define CTRL_TB_LSB 1
`define CTRL_TB_MSB 2
`define CTRL_RSTCON_BIT 3
`define CTRL_INDIRECT_BIT 4

// Status register fields.
`define ST_OUT_BIT 0
`define ST_RUN_BIT 1
`define ST_TRIG_BIT 2
`define ST_RST_BIT 3

// Reset values.
`define PRESET_INIT 16'h000A
`define RSTCON_INIT 1'h1

// Timing: clock period and the 1 ms unit, both in ns.
`define CLK_PERIOD_NS 32'h5
`define UNIT_1MS_NS 32'hF4240
`define CYCLES_PER_MS (`UNIT_1MS_NS / `CLK_PERIOD_NS)
`define DECADE_LAST 4'h9
`define PRESCALE_W 18

`endif

/* shared/pulse_timer_pkg.sv */
`include "pulse_timer_params.svh"

package pulse_timer_pkg;

  typedef enum logic [0:0] {INPUT_PRECEDENCE, TIME_PRECEDENCE} termination_mode_t;

  typedef enum logic [1:0] {UNIT_1S, UNIT_100MS, UNIT_10MS, UNIT_1MS} time_base_select_t;

  typedef enum logic [0:0] {IDLE, COUNTING} timer_state_t;

  typedef struct packed {
    timer_state_t state;
    logic [15:0] count;
    logic out;
    logic [15:0] preset;
    termination_mode_t mode;
    time_base_select_t tbsel;
    logic reset_connected;
    logic preset_indirect;
    logic trig_s1;
    logic trig_s2;
    logic trig_prev;
    logic rst_s1;
    logic rst_s2;
    logic [31:0] rdata;
  } timer_regs_t;

  typedef struct packed {
    logic [`PRESCALE_W-1:0] prescale;
    logic [2:0][3:0] decade;
  } divider_regs_t;

endpackage : pulse_timer_pkg

/* shared/tick_if.sv */
`timescale 1ns/100ps

interface tick_if;
  logic restart;
  pulse_timer_pkg::time_base_select_t sel;
  logic tick;
  modport timer (output restart, output sel, input tick);
  modport divider (input restart, input sel, output tick);
endinterface : tick_if

/* design/time_base_divider.sv */
`timescale 1ns/100ps
`include "pulse_timer_params.svh"

module time_base_divider #(
  parameter int unsigned CYCLES_PER_MS = `CYCLES_PER_MS
) (
  input wire logic clock,
  input wire logic nrst,
  tick_if.divider tb
);

  pulse_timer_pkg::divider_regs_t q;
  pulse_timer_pkg::divider_regs_t d;
  logic [3:0] carry;

  assign carry[0] = (q.prescale == `PRESCALE_W'(CYCLES_PER_MS - 1));

  // Each decade passes a carry on when it wraps, giving 10 ms, 100 ms and 1 s.
  for (genvar i = 0; i < 3; i++) begin : g_decade
    assign carry[i+1] = carry[i] && (q.decade[i] == `DECADE_LAST);
  end

  always_comb begin
    d = q;
    tb.tick = 1'b0;
    if (tb.restart) begin
      // Restarting with the pulse makes every unit period full length.
      d = '0;
    end else begin
      d.prescale = carry[0] ? '0 : q.prescale + `PRESCALE_W'(1);
      for (int i = 0; i < 3; i++) begin
        if (carry[i]) begin
          d.decade[i] = (q.decade[i] == `DECADE_LAST) ? 4'h0 : q.decade[i] + 4'h1;
        end
      end
      case (tb.sel)
        pulse_timer_pkg::UNIT_1S: tb.tick = carry[3];
        pulse_timer_pkg::UNIT_100MS: tb.tick = carry[2];
        pulse_timer_pkg::UNIT_10MS: tb.tick = carry[1];
        default: tb.tick = carry[0];
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  chk_tick_single_cycle: assert property (@(posedge clock) disable iff (!nrst) tb.tick |=> !tb.tick)
    else $error("time-base tick lasted more than one cycle");

endmodule : time_base_divider

/* design/one_shot_pulse_block.sv */
`timescale 1ns/100ps
`include "pulse_timer_params.svh"

module one_shot_pulse_block #(
  parameter int unsigned CYCLES_PER_MS = `CYCLES_PER_MS
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic trigger_in,
  input wire logic reset_in,
  input wire logic [15:0] preset_data_in,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic pulse_out
);

  pulse_timer_pkg::timer_regs_t q;
  pulse_timer_pkg::timer_regs_t d;
  logic [15:0] preset_eff;
  logic reset_active;
  logic trig_rise;
  logic restart;

  tick_if tbus ();

  time_base_divider #(
    .CYCLES_PER_MS(CYCLES_PER_MS)
  ) u_divider (
    .clock(clock),
    .nrst(nrst),
    .tb(tbus.divider)
  );

  assign tbus.restart = restart;
  assign tbus.sel = q.tbsel;

  // The indirect source is a data register on this clock, so it is read unsynchronised.
  assign preset_eff = q.preset_indirect ? preset_data_in : q.preset;

  assign reset_active = q.reset_connected && q.rst_s2;
  assign trig_rise = q.trig_s2 && !q.trig_prev;

  function automatic logic [31:0] read_word(
    input logic [3:0] addr,
    input pulse_timer_pkg::timer_regs_t r,
    input logic rst_act
  );
    logic [31:0] w;
    w = 32'h0;
    if (addr == `CTRL_OFS) begin
      w[`CTRL_MODE_BIT] = r.mode;
      w[`CTRL_TB_MSB:`CTRL_TB_LSB] = r.tbsel;
      w[`CTRL_RSTCON_BIT] = r.reset_connected;
      w[`CTRL_INDIRECT_BIT] = r.preset_indirect;
    end else if (addr == `PRESET_OFS) begin
      w[15:0] = r.preset;
    end else if (addr == `STATUS_OFS) begin
      w[`ST_OUT_BIT] = r.out;
      w[`ST_RUN_BIT] = (r.state == pulse_timer_pkg::COUNTING);
      w[`ST_TRIG_BIT] = r.trig_s2;
      w[`ST_RST_BIT] = rst_act;
    end else if (addr == `COUNT_OFS) begin
      w[15:0] = r.count;
    end
    return w;
  endfunction : read_word

  always_comb begin
    d = q;
    restart = 1'b0;

    // Both pins are asynchronous to this clock and pass two flops first.
    d.trig_s1 = trigger_in;
    d.trig_s2 = q.trig_s1;
    d.trig_prev = q.trig_s2;
    d.rst_s1 = reset_in;
    d.rst_s2 = q.rst_s1;

    if (reg_wr) begin
      if (reg_addr == `CTRL_OFS) begin
        d.mode = pulse_timer_pkg::termination_mode_t'(reg_wdata[`CTRL_MODE_BIT]);
        d.tbsel = pulse_timer_pkg::time_base_select_t'(reg_wdata[`CTRL_TB_MSB:`CTRL_TB_LSB]);
        d.reset_connected = reg_wdata[`CTRL_RSTCON_BIT];
        d.preset_indirect = reg_wdata[`CTRL_INDIRECT_BIT];
      end else if (reg_addr == `PRESET_OFS) begin
        d.preset = reg_wdata[15:0];
      end
    end

    d.rdata = 32'h0;
    if (reg_rd) begin
      d.rdata = read_word(reg_addr, q, reset_active);
    end

    if (reset_active) begin
      d.out = 1'b0;
      d.state = pulse_timer_pkg::IDLE;
      d.count = 16'h0;
    end else if (trig_rise) begin
      d.count = 16'h0;
      restart = 1'b1;
      if (preset_eff == 16'h0) begin
        d.out = 1'b0;
        d.state = pulse_timer_pkg::IDLE;
      end else begin
        d.out = 1'b1;
        d.state = pulse_timer_pkg::COUNTING;
      end
    end else if (q.state == pulse_timer_pkg::COUNTING) begin
      if (q.mode == pulse_timer_pkg::INPUT_PRECEDENCE && !q.trig_s2) begin
        d.out = 1'b0;
        d.state = pulse_timer_pkg::IDLE;
      end else if (q.count >= preset_eff) begin
        // A preset lowered to or under the running count ends the pulse here.
        d.out = 1'b0;
        d.state = pulse_timer_pkg::IDLE;
      end else if (tbus.tick) begin
        d.count = q.count + 16'h1;
        if (d.count == preset_eff) begin
          d.out = 1'b0;
          d.state = pulse_timer_pkg::IDLE;
        end
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      q <= '0;
      q.mode <= pulse_timer_pkg::INPUT_PRECEDENCE;
      q.preset <= `PRESET_INIT;
      q.reset_connected <= `RSTCON_INIT;
    end else begin
      q <= d;
    end
  end

  assign pulse_out = q.out;
  assign reg_rdata = q.rdata;

  default clocking dcb @(posedge clock);
  endclocking
  default disable iff (!nrst);

  chk_reset_forces_low: assert property (reset_active |=> !pulse_out)
    else $error("output not low after active reset");

  chk_reset_no_tick: assert property (reset_active && pulse_out |=> !pulse_out && q.count == 16'h0)
    else $error("reset did not end the pulse at once");

  chk_rise_starts_pulse: assert property (
    !reset_active && trig_rise && preset_eff != 16'h0 |=> pulse_out && q.count == 16'h0)
    else $error("trigger edge did not start a fresh pulse");

  chk_zero_preset_none: assert property (
    !reset_active && trig_rise && preset_eff == 16'h0 |=> !pulse_out ##1 !pulse_out)
    else $error("zero preset produced an output pulse");

  chk_input_prec_drop: assert property (
    q.state == pulse_timer_pkg::COUNTING && q.mode == pulse_timer_pkg::INPUT_PRECEDENCE
    && !q.trig_s2 && !reset_active |=> !pulse_out)
    else $error("input precedence kept output after trigger fell");

  chk_time_prec_hold: assert property (
    pulse_out && q.mode == pulse_timer_pkg::TIME_PRECEDENCE && !q.trig_s2 && !reset_active
    && q.count < preset_eff && !(tbus.tick && q.count + 16'h1 == preset_eff) |=> pulse_out)
    else $error("time precedence dropped output early");

  chk_reach_stops: assert property (
    pulse_out && !reset_active && !trig_rise && !(q.mode == pulse_timer_pkg::INPUT_PRECEDENCE && !q.trig_s2)
    && tbus.tick && q.count + 16'h1 == preset_eff |=> !pulse_out && q.state == pulse_timer_pkg::IDLE)
    else $error("output stayed high with count at preset");

  // The output may only stand while the count runs, so an idle timer never shows a pulse.
  chk_out_needs_count: assert property (pulse_out |-> q.state == pulse_timer_pkg::COUNTING)
    else $error("output high while the timer is idle");

  chk_preset_below: assert property (
    q.state == pulse_timer_pkg::COUNTING && !reset_active && !trig_rise && q.count >= preset_eff
    |=> !pulse_out && $stable(q.count))
    else $error("preset at or below count did not stop the pulse");

  chk_preset_above: assert property (
    pulse_out && !reset_active && !tbus.tick && q.count < preset_eff && q.trig_s2 |=> pulse_out)
    else $error("pulse ended before count reached preset");

  chk_count_only_tick: assert property (
    q.state == pulse_timer_pkg::COUNTING && !reset_active && !trig_rise && !tbus.tick
    |=> $stable(q.count))
    else $error("count moved without a time-base tick");

  chk_idle_count_hold: assert property (
    q.state == pulse_timer_pkg::IDLE && !reset_active && !trig_rise |=> $stable(q.count))
    else $error("count moved while the timer was idle");

  chk_count_step: assert property (
    q.state == pulse_timer_pkg::COUNTING && !reset_active && !trig_rise && tbus.tick && q.count < preset_eff
    && !(q.mode == pulse_timer_pkg::INPUT_PRECEDENCE && !q.trig_s2) |=> q.count == $past(q.count) + 16'h1)
    else $error("count did not advance by one on a tick");

  // A high reset pin must not cut a running pulse while the reset is marked unconnected.
  chk_unconnected_reset: assert property (
    !q.reset_connected && q.rst_s2 && pulse_out && q.trig_s2 && !tbus.tick && q.count < preset_eff
    |=> pulse_out)
    else $error("reset acted while marked unconnected");

  chk_status_read: assert property (
    reg_rd && reg_addr == `STATUS_OFS
    |=> reg_rdata[`ST_OUT_BIT] == $past(pulse_out) && reg_rdata[`ST_RST_BIT] == $past(reset_active))
    else $error("status read did not show output and reset state");

  chk_preset_readback: assert property (
    reg_rd && reg_addr == `PRESET_OFS |=> reg_rdata == {16'h0000, $past(q.preset)})
    else $error("preset read did not return the stored preset");

  chk_preset_restore: assert property (
    @(posedge clock) disable iff (1'b0) !nrst |=> q.preset == `PRESET_INIT)
    else $error("preset not restored by reset");

  chk_default_mode: assert property (
    @(posedge clock) disable iff (1'b0) !nrst |=> q.mode == pulse_timer_pkg::INPUT_PRECEDENCE)
    else $error("default mode is not input precedence");

endmodule : one_shot_pulse_block

/* tb/pulse_ctrl_model.sv */
`timescale 1ns/100ps

module pulse_ctrl_model (
  input wire logic clock,
  input wire logic trig_req,
  input wire logic rst_req,
  input wire logic [15:0] data_req,
  output logic trigger_in,
  output logic reset_in,
  output logic [15:0] preset_data_in
);
  // Outputs change only after a clock edge, as a real controller's would.
  logic trig_q = 1'b0;
  logic rst_q = 1'b0;
  logic [15:0] data_q = 16'h0000;

  always @(posedge clock) begin
    trig_q <= trig_req;
    rst_q <= rst_req;
    data_q <= data_req;
  end

  assign trigger_in = trig_q;
  assign reset_in = rst_q;
  assign preset_data_in = data_q;
endmodule : pulse_ctrl_model

/* tb/single_shot_pulse_timer_tb_top.sv */
`timescale 1ns/100ps
`include "pulse_timer_params.svh"

module single_shot_pulse_timer_tb_top;
  // A short unit keeps the one second case to a few thousand cycles.
  localparam int N = 8;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic trig = 1'b0;
  logic rst = 1'b0;
  logic [15:0] pdata = 16'h0000;
  logic trigger_in;
  logic reset_in;
  logic [15:0] preset_data_in;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h00000000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic pulse_out;
  int errors = 0;
  int checks_done = 0;
  int w;
  int u;
  int mult [4] = '{1000, 100, 10, 1};

  initial begin
    forever #2.5 clock = ~clock;
  end

  pulse_ctrl_model ctrl_u (
    .clock(clock),
    .trig_req(trig),
    .rst_req(rst),
    .data_req(pdata),
    .trigger_in(trigger_in),
    .reset_in(reset_in),
    .preset_data_in(preset_data_in)
  );

  one_shot_pulse_block #(.CYCLES_PER_MS(N)) dut_u (
    .clock(clock),
    .nrst(nrst),
    .trigger_in(trigger_in),
    .reset_in(reset_in),
    .preset_data_in(preset_data_in),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .pulse_out(pulse_out)
  );

  task automatic summarize();
    $display("errors=%0d checks_done=%0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : summarize

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t: read %h, expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_w(input int got, input int lo, input int hi);
    checks_done++;
    if (got < lo || got > hi) begin
      errors++;
      $display("ERROR %0t: width %0d, expected %0d..%0d", $time, got, lo, hi);
    end
  endtask : chk_w

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(negedge clock);
    chk(reg_rdata, exp);
  endtask : rd

  // Counts the cycles the output stays high; a stuck output ends the run.
  task automatic measure(output int width);
    int i;
    width = 0;
    for (i = 0; i < 16 && pulse_out !== 1'b1; i++) @(negedge clock);
    while (pulse_out === 1'b1 && width < 9000) begin
      @(negedge clock);
      width++;
    end
    if (width >= 9000) begin
      errors++;
      summarize();
    end
    // An unknown output keeps the first loop waiting all 16 cycles and ends the second at once; a negative width fails every range check.
    if (pulse_out !== 1'b0) begin
      width = -1;
    end
  endtask : measure

  task automatic fire(input int hold, output int width);
    @(posedge clock);
    trig <= 1'b1;
    fork
      measure(width);
      begin
        repeat (hold) @(posedge clock);
        trig <= 1'b0;
      end
    join
    repeat (4) @(posedge clock);
  endtask : fire

  initial begin
    repeat (12) @(posedge clock);
    nrst <= 1'b1;
    rd(`CTRL_OFS, 32'h00000008);
    rd(`PRESET_OFS, 32'h0000000A);
    rd(4'h2, 32'h00000000);
    for (u = 0; u < 4; u++) begin
      wr(`CTRL_OFS, 32'h00000009 | 32'(u << 1));
      wr(`PRESET_OFS, 32'h00000001);
      fire(4, w);
      chk_w(w, mult[u] * N, mult[u] * N + 1);
    end
    wr(`PRESET_OFS, 32'h00000003);
    fire(4, w);
    chk_w(w, 3 * N, 3 * N + 1);
    rd(`COUNT_OFS, 32'h00000003);
    wr(`CTRL_OFS, 32'h0000000E);
    fire(4, w);
    chk_w(w, 3, 5);
    wr(`CTRL_OFS, 32'h0000000F);
    fork
      fire(4, w);
      begin
        repeat (14) @(posedge clock);
        trig <= 1'b1;
        repeat (4) @(posedge clock);
        trig <= 1'b0;
      end
    join
    chk_w(w, 35, 39);
    fork
      fire(4, w);
      begin
        repeat (12) @(posedge clock);
        wr(`PRESET_OFS, 32'h00000005);
        rd(`STATUS_OFS, 32'h00000003);
      end
    join
    chk_w(w, 39, 41);
    fork
      fire(4, w);
      begin
        repeat (24) @(posedge clock);
        wr(`PRESET_OFS, 32'h00000001);
      end
    join
    chk_w(w, 18, 24);
    wr(`PRESET_OFS, 32'h00000000);
    fire(4, w);
    chk_w(w, 0, 0);
    wr(`PRESET_OFS, 32'h00000003);
    fork
      fire(4, w);
      begin
        repeat (10) @(posedge clock);
        rst <= 1'b1;
      end
    join
    chk_w(w, 6, 12);
    fire(4, w);
    chk_w(w, 0, 0);
    rd(`STATUS_OFS, 32'h00000008);
    wr(`CTRL_OFS, 32'h00000007);
    fire(4, w);
    chk_w(w, 3 * N, 3 * N + 1);
    rst <= 1'b0;
    pdata <= 16'h0002;
    wr(`CTRL_OFS, 32'h0000001F);
    fire(4, w);
    chk_w(w, 2 * N, 2 * N + 1);
    wr(`PRESET_OFS, 32'hFFFFFFFF);
    rd(`PRESET_OFS, 32'h0000FFFF);
    wr(`PRESET_OFS, 32'h00000007);
    @(posedge clock);
    nrst <= 1'b0;
    repeat (2) @(posedge clock);
    nrst <= 1'b1;
    rd(`PRESET_OFS, 32'h0000000A);
    summarize();
  end
endmodule : single_shot_pulse_timer_tb_top
